// ---- host_serial_control_port.sv ----
// Register core, mode strap and alarm interrupt of the host serial port
`timescale 1ns/1ps
`default_nettype none
`include "host_serial_cfg.svh"
module host_serial_control_port (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic control_mode_strap,
    input wire logic serial_clk,
    input wire logic select_n,
    input wire logic serial_port_in,
    output logic serial_port_out,
    output logic serial_port_out_oe,
    input wire logic [7:0] alarm_status,
    input wire logic [7:0] hw_config,
    output logic [7:0] config_out,
    output logic [7:0] config_aux,
    output logic int_n_out,
    output logic int_n_oe
);
    reg_access_if link_bus ();

    serial_port_link link_end (
        .serial_clk(serial_clk),
        .select_n(select_n),
        .serial_port_in(serial_port_in),
        .serial_port_out(serial_port_out),
        .serial_port_out_oe(serial_port_out_oe),
        .port(link_bus.link)
    );

    logic strap_s1;
    logic strap_s2;
    logic csn_s1;
    logic csn_s2;
    logic [2:0] wt_s;
    logic [2:0] rt_s;
    host_serial_pkg::byte_t alarm_s1;
    host_serial_pkg::byte_t alarm_s2;
    host_serial_pkg::byte_t alarm_prev;
    host_serial_pkg::byte_t hw_s1;
    host_serial_pkg::byte_t hw_s2;
    host_serial_pkg::byte_t cfg0;
    host_serial_pkg::byte_t cfg1;
    host_serial_pkg::byte_t stat;
    host_serial_pkg::byte_t next_cfg0;
    host_serial_pkg::byte_t next_cfg1;
    host_serial_pkg::byte_t next_stat;
    host_serial_pkg::byte_t next_config_out;
    host_serial_pkg::byte_t change;
    logic next_int_n_oe;
    logic host;
    logic wr_edge;
    logic rd_edge;

    assign host = strap_s2;
    assign wr_edge = wt_s[2] ^ wt_s[1];
    assign rd_edge = rt_s[2] ^ rt_s[1];

    always_comb begin
        change = host ? (alarm_s2 ^ alarm_prev) : `BYTE_ZERO;
        next_cfg0 = cfg0;
        next_cfg1 = cfg1;
        if (host && wr_edge) begin
            if (link_bus.wr_addr == `ADDR_CFG0) begin
                next_cfg0 = link_bus.wr_data;
            end
            if (link_bus.wr_addr == `ADDR_CFG1) begin
                next_cfg1 = link_bus.wr_data;
            end
        end
        // Only bits the host actually saw are cleared; a new change wins
        next_stat = stat;
        if (host && rd_edge) begin
            next_stat = stat & ~link_bus.rd_val;
        end
        next_stat = next_stat | change;
        next_int_n_oe = host && (|next_stat);
        next_config_out = host ? next_cfg0 : hw_s2;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            strap_s1 <= 1'h0;
            strap_s2 <= 1'h0;
            csn_s1 <= 1'h1;
            csn_s2 <= 1'h1;
            wt_s <= 3'h0;
            rt_s <= 3'h0;
            alarm_s1 <= `BYTE_ZERO;
            alarm_s2 <= `BYTE_ZERO;
            alarm_prev <= `BYTE_ZERO;
            hw_s1 <= `BYTE_ZERO;
            hw_s2 <= `BYTE_ZERO;
            cfg0 <= `BYTE_ZERO;
            cfg1 <= `BYTE_ZERO;
            stat <= `BYTE_ZERO;
            config_out <= `BYTE_ZERO;
            config_aux <= `BYTE_ZERO;
            int_n_oe <= 1'h0;
            int_n_out <= 1'h0;
            link_bus.host_mode <= 1'h0;
            link_bus.link_rst <= 1'h1;
            for (int i = 0; i < 4; i++) begin
                link_bus.rd_bank[i] <= `BYTE_ZERO;
            end
        end else begin
            strap_s1 <= control_mode_strap;
            strap_s2 <= strap_s1;
            csn_s1 <= select_n;
            csn_s2 <= csn_s1;
            wt_s <= {wt_s[1:0], link_bus.wr_toggle};
            rt_s <= {rt_s[1:0], link_bus.rd_toggle};
            alarm_s1 <= alarm_status;
            alarm_s2 <= alarm_s1;
            alarm_prev <= alarm_s2;
            hw_s1 <= hw_config;
            hw_s2 <= hw_s1;
            cfg0 <= next_cfg0;
            cfg1 <= next_cfg1;
            stat <= next_stat;
            config_out <= next_config_out;
            config_aux <= next_cfg1;
            int_n_oe <= next_int_n_oe;
            int_n_out <= 1'h0;
            link_bus.host_mode <= strap_s2;
            link_bus.link_rst <= 1'h0;
            // Frozen while selected so the link reads a steady snapshot
            if (csn_s2) begin
                link_bus.rd_bank[0] <= next_cfg0;
                link_bus.rd_bank[1] <= next_cfg1;
                link_bus.rd_bank[2] <= next_stat;
                link_bus.rd_bank[3] <= alarm_s2;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence status_cleared_s;
        host && rd_edge && (stat & ~link_bus.rd_val) == `BYTE_ZERO && change == `BYTE_ZERO;
    endsequence

    sequence cfg_write_s;
        host && wr_edge && link_bus.wr_addr == `ADDR_CFG0;
    endsequence

    mode_pins_a: assert property (!host |=> config_out == $past(hw_s2))
        else $error("hardware mode not following pins");

    reg_write_a: assert property (cfg_write_s |=> config_out == $past(link_bus.wr_data))
        else $error("serial write not applied");

    hw_ignore_a: assert property (!host |=> $stable(cfg0) && $stable(cfg1))
        else $error("write accepted in hardware mode");

    alarm_int_a: assert property (change != `BYTE_ZERO |=> int_n_oe &&
        (stat & $past(change)) == $past(change))
        else $error("alarm change did not raise interrupt");

    int_release_a: assert property (status_cleared_s |=> !int_n_oe)
        else $error("interrupt not released after status read");

    open_drain_a: assert property (int_n_out == 1'h0 && (!int_n_oe || $past(host)))
        else $error("interrupt pin driven high or outside host mode");

    snapshot_hold_a: assert property (!csn_s2 |=> $stable(link_bus.rd_bank[2]))
        else $error("read snapshot changed during a frame");

    sequence aux_write_s;
        host && wr_edge && link_bus.wr_addr == `ADDR_CFG1;
    endsequence

    sequence stray_write_s;
        host && wr_edge && link_bus.wr_addr > `ADDR_CFG1;
    endsequence

    // Status may only move on a new change or a returned status read
    sequence status_idle_s;
        !rd_edge && change == `BYTE_ZERO;
    endsequence

    aux_write_a: assert property (aux_write_s |=> config_aux == $past(link_bus.wr_data))
        else $error("aux register write not applied");

    stray_write_a: assert property (stray_write_s |=> $stable(cfg0) && $stable(cfg1))
        else $error("write to an unmapped address changed a register");

    cfg_hold_a: assert property (host && !wr_edge |=> $stable(cfg0) && $stable(cfg1))
        else $error("register changed without a write");

    status_hold_a: assert property (status_idle_s |=> $stable(stat))
        else $error("status changed with no event and no read");

    hw_quiet_a: assert property (!host |=> !int_n_oe)
        else $error("interrupt driven in hardware mode");

    int_level_a: assert property (int_n_oe |-> stat != `BYTE_ZERO)
        else $error("interrupt driven with no status bit set");

    snap_refresh_a: assert property (csn_s2 |=> link_bus.rd_bank[2] == $past(next_stat))
        else $error("read snapshot not refreshed while deselected");

    live_alarm_a: assert property (csn_s2 |=> link_bus.rd_bank[3] == $past(alarm_s2))
        else $error("live alarm snapshot not refreshed");

    strap_follow_a: assert property (host == $past(strap_s1))
        else $error("mode strap synchroniser out of step");
endmodule
`default_nettype wire

// ---- host_serial_cfg.svh ----
// Constants of the host serial control port
// What this block does
// - Strap low or open selects pin control; strap high selects serial register control
// - In host mode the serial port reads and writes individual internal registers
// - Serial port works only while select is low; select high disables it
// - One transaction takes exactly sixteen serial clocks after select falls
// - Serial input is sampled on every rising serial clock edge while selected
// - Read data leaves on falling edges of clocks 8 to 15, LSB first
// - Select, clock, input and output act only in host mode
// - In host mode any alarm status change pulls the interrupt low
// - Interrupt releases high once the host has read the status register
// - Interrupt is open drain: pulled low only, external pull-up gives high
`ifndef HOST_SERIAL_CFG_SVH
`define HOST_SERIAL_CFG_SVH
`define ADDR_CFG0 7'h00
`define ADDR_CFG1 7'h01
`define ADDR_STAT 7'h02
`define ADDR_LIVE 7'h03
`define ADDR_LAST 7'h03
`define HDR_CLKS 5'h08
`define LAST_CLK 5'h0F
`define FRAME_CLKS 5'h10
`define BYTE_ZERO 8'h00
`endif

// ---- host_serial_pkg.sv ----
// Types shared by the host serial control port
package host_serial_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] addr_t;
endpackage

// ---- reg_access_if.sv ----
// Crossing signals between the serial link and the register core
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
    logic host_mode;
    logic link_rst;
    host_serial_pkg::byte_t rd_bank [0:3];
    logic wr_toggle;
    host_serial_pkg::addr_t wr_addr;
    host_serial_pkg::byte_t wr_data;
    logic rd_toggle;
    host_serial_pkg::byte_t rd_val;
    modport core (output host_mode, output link_rst, output rd_bank,
                  input wr_toggle, input wr_addr, input wr_data, input rd_toggle, input rd_val);
    modport link (input host_mode, input link_rst, input rd_bank,
                  output wr_toggle, output wr_addr, output wr_data, output rd_toggle, output rd_val);
endinterface
`default_nettype wire

// ---- serial_port_link.sv ----
// Serial clock domain: frame counter, shifter and read data output
`timescale 1ns/1ps
`default_nettype none
`include "host_serial_cfg.svh"
module serial_port_link (
    input wire logic serial_clk,
    input wire logic select_n,
    input wire logic serial_port_in,
    output logic serial_port_out,
    output logic serial_port_out_oe,
    reg_access_if.link port
);
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    host_serial_pkg::byte_t hdr;
    host_serial_pkg::byte_t next_hdr;
    host_serial_pkg::byte_t dat;
    host_serial_pkg::byte_t next_dat;
    logic next_wr_toggle;
    logic next_rd_toggle;
    host_serial_pkg::addr_t next_wr_addr;
    host_serial_pkg::byte_t next_wr_data;
    host_serial_pkg::byte_t next_rd_val;
    logic mode_s1;
    logic mode_s2;
    logic next_sdo;
    logic next_sdo_oe;
    logic is_read;
    host_serial_pkg::addr_t addr;
    host_serial_pkg::byte_t rdata;

    assign is_read = hdr[0];
    assign addr = hdr[7:1];

    always_comb begin
        rdata = `BYTE_ZERO;
        if (addr <= `ADDR_LAST) begin
            rdata = port.rd_bank[addr[1:0]];
        end
    end

    // Frame state clears with select high because the clock stops between frames
    always_comb begin
        next_cnt = cnt;
        next_hdr = hdr;
        next_dat = dat;
        if (cnt < `FRAME_CLKS) begin
            next_cnt = cnt + 5'h01;
        end
        if (cnt < `HDR_CLKS) begin
            next_hdr = {serial_port_in, hdr[7:1]};
        end else if (cnt < `FRAME_CLKS) begin
            next_dat = {serial_port_in, dat[7:1]};
        end
    end

    always_ff @(posedge serial_clk or posedge select_n) begin
        if (select_n) begin
            cnt <= 5'h00;
            hdr <= `BYTE_ZERO;
            dat <= `BYTE_ZERO;
        end else begin
            cnt <= next_cnt;
            hdr <= next_hdr;
            dat <= next_dat;
        end
    end

    // Events leave as toggles; the data stays put until the next frame
    always_comb begin
        next_wr_toggle = port.wr_toggle;
        next_rd_toggle = port.rd_toggle;
        next_wr_addr = port.wr_addr;
        next_wr_data = port.wr_data;
        next_rd_val = port.rd_val;
        if (!select_n && mode_s2 && cnt == `LAST_CLK) begin
            if (!is_read) begin
                next_wr_toggle = ~port.wr_toggle;
                next_wr_addr = addr;
                next_wr_data = {serial_port_in, dat[7:1]};
            end else if (addr == `ADDR_STAT) begin
                next_rd_toggle = ~port.rd_toggle;
                next_rd_val = rdata;
            end
        end
    end

    always_ff @(posedge serial_clk or posedge port.link_rst) begin
        if (port.link_rst) begin
            port.wr_toggle <= 1'h0;
            port.rd_toggle <= 1'h0;
            port.wr_addr <= 7'h00;
            port.wr_data <= `BYTE_ZERO;
            port.rd_val <= `BYTE_ZERO;
            mode_s1 <= 1'h0;
            mode_s2 <= 1'h0;
        end else begin
            port.wr_toggle <= next_wr_toggle;
            port.rd_toggle <= next_rd_toggle;
            port.wr_addr <= next_wr_addr;
            port.wr_data <= next_wr_data;
            port.rd_val <= next_rd_val;
            mode_s1 <= port.host_mode;
            mode_s2 <= mode_s1;
        end
    end

    always_comb begin
        next_sdo = serial_port_out;
        next_sdo_oe = 1'h0;
        if (mode_s2 && is_read && cnt >= `HDR_CLKS && cnt < `FRAME_CLKS) begin
            next_sdo_oe = 1'h1;
            next_sdo = rdata[cnt[2:0]];
        end
    end

    always_ff @(negedge serial_clk or posedge select_n) begin
        if (select_n) begin
            serial_port_out <= 1'h0;
            serial_port_out_oe <= 1'h0;
        end else begin
            serial_port_out <= next_sdo;
            serial_port_out_oe <= next_sdo_oe;
        end
    end

    input_sample_a: assert property (@(posedge serial_clk) disable iff (select_n)
        cnt < `HDR_CLKS |=> hdr[7] == $past(serial_port_in))
        else $error("serial input not sampled on rising edge");

    read_bits_a: assert property (@(posedge serial_clk) disable iff (select_n)
        (mode_s2 && is_read && cnt >= `HDR_CLKS && cnt < `FRAME_CLKS)
        |-> serial_port_out_oe && serial_port_out == rdata[cnt[2:0]])
        else $error("read bit wrong or late");

    write_event_a: assert property (@(posedge serial_clk) disable iff (port.link_rst)
        (!select_n && mode_s2 && !is_read && cnt == `LAST_CLK)
        |=> port.wr_toggle != $past(port.wr_toggle) && port.wr_addr == $past(addr))
        else $error("write not issued at clock sixteen");
endmodule
`default_nettype wire

// ---- serial_host_model.sv ----
// Host-side model that runs serial frames against the control port
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    output logic serial_clk,
    output logic select_n,
    output logic serial_port_in,
    input wire logic serial_port_out,
    input wire logic serial_port_out_oe
);
    initial begin
        serial_clk = 1'b0;
        select_n = 1'b0;
        serial_port_in = 1'b0;
        // A select rise before any clock clears the link frame state
        #2 select_n = 1'b1;
    end
    // Clock idles low between frames; input falls to its pull-down level
    task automatic xfer(input logic rd, input host_serial_pkg::addr_t addr,
                        input host_serial_pkg::byte_t wdata,
                        output host_serial_pkg::byte_t rdata, output logic oe_seen);
        logic [15:0] bits;
        bits = {wdata, addr, rd};
        rdata = 8'h00;
        oe_seen = 1'b0;
        // Off the core clock edge; the link clock keeps its own phase
        #3;
        select_n = 1'b0;
        #7.5;
        for (int k = 1; k <= 16; k++) begin
            serial_port_in = bits[k-1];
            #7.5 serial_clk = 1'b1;
            if (k >= 9) begin
                // A released line reads inverted so late driving shows up
                rdata[k-9] = serial_port_out_oe ? serial_port_out : ~serial_port_out;
                oe_seen = oe_seen | serial_port_out_oe;
            end
            #7.5 serial_clk = 1'b0;
        end
        #7.5;
        select_n = 1'b1;
        serial_port_in = 1'b0;
        // Deselect gap lets the snapshot refresh and the events cross
        #40;
    endtask
endmodule
`default_nettype wire

// ---- host_serial_control_port_bench.sv ----
// Self-checking bench for the host serial control port
`timescale 1ns/1ps
`default_nettype none
module host_serial_control_port_bench;
    logic ref_clk, reset, strap, serial_clk, select_n, serial_port_in;
    logic serial_port_out, serial_port_out_oe, int_n_out, int_n_oe, int_line, oe;
    logic [7:0] alarm_status, hw_config, config_out, config_aux;
    host_serial_pkg::byte_t rd;
    int fail_count, checks_done, cycles;

    host_serial_control_port dut_u (.ref_clk(ref_clk), .reset(reset),
        .control_mode_strap(strap), .serial_clk(serial_clk), .select_n(select_n),
        .serial_port_in(serial_port_in), .serial_port_out(serial_port_out),
        .serial_port_out_oe(serial_port_out_oe), .alarm_status(alarm_status),
        .hw_config(hw_config), .config_out(config_out), .config_aux(config_aux),
        .int_n_out(int_n_out), .int_n_oe(int_n_oe));
    serial_host_model host_u (.serial_clk(serial_clk), .select_n(select_n),
        .serial_port_in(serial_port_in), .serial_port_out(serial_port_out),
        .serial_port_out_oe(serial_port_out_oe));

    // Open-drain line with external pull-up
    assign int_line = int_n_oe ? int_n_out : 1'b1;

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic settle();
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic t_write_read();
        host_u.xfer(1'b0, 7'h00, 8'hA5, rd, oe);
        settle();
        chk8(config_out, 8'hA5);
        host_u.xfer(1'b0, 7'h01, 8'h3C, rd, oe);
        settle();
        chk8(config_aux, 8'h3C);
        host_u.xfer(1'b1, 7'h01, 8'h00, rd, oe);
        chk8(rd, 8'h3C);
        chk1(oe, 1'b1);
        chk1(serial_port_out_oe, 1'b0);
        settle();
        host_u.xfer(1'b0, 7'h05, 8'hFF, rd, oe);
        settle();
        host_u.xfer(1'b1, 7'h05, 8'h00, rd, oe);
        chk8(rd, 8'h00);
        settle();
    endtask

    task automatic t_alarm();
        @(posedge ref_clk);
        alarm_status <= 8'h81;
        settle();
        chk1(int_line, 1'b0);
        chk1(int_n_out, 1'b0);
        host_u.xfer(1'b1, 7'h03, 8'h00, rd, oe);
        settle();
        chk1(int_line, 1'b0);
        host_u.xfer(1'b1, 7'h02, 8'h00, rd, oe);
        chk8(rd, 8'h81);
        settle();
        chk1(int_line, 1'b1);
    endtask

    task automatic t_hw_mode();
        @(posedge ref_clk);
        strap <= 1'b0;
        hw_config <= 8'h6B;
        settle();
        chk8(config_out, 8'h6B);
        host_u.xfer(1'b0, 7'h00, 8'h11, rd, oe);
        settle();
        host_u.xfer(1'b1, 7'h00, 8'h00, rd, oe);
        chk1(oe, 1'b0);
        @(posedge ref_clk);
        alarm_status <= 8'h00;
        settle();
        chk1(int_line, 1'b1);
        @(posedge ref_clk);
        strap <= 1'b1;
        settle();
        chk8(config_out, 8'hA5);
        chk1(int_line, 1'b1);
    endtask

    initial begin
        fail_count = 0;
        checks_done = 0;
        cycles = 0;
        reset = 1'b1;
        strap = 1'b1;
        alarm_status = 8'h00;
        hw_config = 8'h00;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        settle();
        chk1(int_line, 1'b1);
        chk8(config_out, 8'h00);
        t_write_read();
        t_alarm();
        t_hw_mode();
        finish_test();
    end
endmodule
`default_nettype wire
